/* rtl/tesc_pkg.sv */
package tesc_pkg;

    localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFF_SLAVE = 32'h0000_0004;
    localparam logic [31:0] OFF_CHAN = 32'h0000_0008;
    localparam logic [31:0] OFF_ARR = 32'h0000_000C;
    localparam logic [31:0] OFF_CMP = 32'h0000_0010;
    localparam logic [31:0] OFF_PSC = 32'h0000_0014;
    localparam logic [31:0] OFF_CNT = 32'h0000_0018;
    localparam logic [31:0] OFF_FLAG = 32'h0000_001C;
    localparam logic [31:0] OFF_IEN = 32'h0000_0020;
    localparam logic [31:0] OFF_EVT = 32'h0000_0024;

    // Control register bits
    localparam int CTRL_CEN = 0;
    localparam int CTRL_URS = 2;
    localparam int CTRL_OPM = 3;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_XOR = 7;
    // Slave register fields
    localparam int SLV_SMS_LSB = 0;
    localparam int SLV_TS_LSB = 4;
    // Channel register fields
    localparam int CH_OCM_LSB = 4;
    localparam int CH_FE = 2;
    localparam int CH_P1 = 8;
    localparam int CH_P2 = 9;
    // Flag / event bits
    localparam int FLG_UIF = 0;
    localparam int FLG_TIF = 6;
    localparam int EVT_UG = 0;

    localparam logic [2:0] SMS_OFF = 3'h0;
    localparam logic [2:0] SMS_ENC2 = 3'h1;
    localparam logic [2:0] SMS_ENC1 = 3'h2;
    localparam logic [2:0] SMS_ENC12 = 3'h3;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_GATED = 3'h5;
    localparam logic [2:0] TS_FIRST = 3'h5;
    localparam logic [2:0] TS_SECOND = 3'h6;
    localparam logic [2:0] OCM_PWM1 = 3'h6;
    localparam logic [2:0] OCM_PWM2 = 3'h7;

    localparam logic [15:0] ARR_RESET = 16'hFFFF;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic first_encoder_input;
        logic second_encoder_input;
        logic chan3;
        logic chan4;
    } tesc_pins_s;

    typedef struct packed {
        logic [15:0] count;
        logic count_direction_bit;
        logic update_event;
        logic channel_reference_signal;
        logic channel_output;
    } tesc_state_s;

endpackage : tesc_pkg

/* rtl/tesc_core.sv */
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// (R1) In one-pulse mode a trigger edge sets the counter enable bit, except in reset, gated and encoder slave modes.
// (R2) Fast enable forces reference and output to match level on trigger.
// (R3) Fast enable only acts in the two PWM modes.
// (R4) Slave mode 001 counts second input, 010 first, 011 both.
// (R5) Encoder mode steps counter once per valid filtered edge, with direction.
// (R6) In encoder modes, direction bit recomputed on every edge of either encoder input.
// (R7) Encoder counting wraps between 0 and the auto-reload value.
// (R8) Compare keeps working in encoder mode; the prescaler and the overflow update stop there, leaving only UG writes as updates.
// (R9) First-input edges: rise counts down if second high, fall reverses.
// (R10) Second-input edges: rise counts up if first high, fall reverses.
// (R11) Both-input mode applies the per-input rules to every edge.
// (R12) XOR select feeds channel 1 from XOR of channel 2, 3, 4 pins.
// (R13) Reset mode trigger clears counter and prescaler.
// (R14) Reset trigger with update source low also raises an update event.
// (R15) Software writes 101 in trigger select to use first input.
// (R16) Reset mode restarts from 0 and sets the trigger flag.
// (R17) Interrupt request raised only if trigger interrupt enable is set.
// (R18) Gated mode counts only while trigger input is active.
// (R19) Gated mode stays stopped while counter enable is 0.
// (R20) Gated mode sets trigger flag on start and stop of counting, except a start or stop in the cycle gated mode is entered.
// (R21) Trigger inputs are resynchronised, delaying the counter reaction.
// (R22) Polarity bit 1 inverts the input; 0 leaves it as is.
// (R23) One-pulse bit clears counter enable at the next update event that is not a UG write.
// (R24) Inputs pass a two-flop synchroniser before edge detection.
// (R25) Trigger flag sticks until cleared; request follows flag and enable.
module tesc_core
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tesc_pkg::tesc_pins_s pins,
    output tesc_pkg::tesc_state_s state,
    output logic trigger_irq
);

    typedef enum logic [2:0] {
        TESC_IDLE = 3'b001,
        TESC_OFF = 3'b010,
        TESC_ON = 3'b100
    } tesc_gate_e;

    function automatic logic [15:0] tesc_step(input logic [15:0] cnt, input logic [15:0] top,
                                              input logic down);
        logic [15:0] r;
        r = 16'h0000;
        if (down)
        begin
            r = (cnt == 16'h0000) ? top : cnt - 16'h0001;
        end
        else
        begin
            r = (cnt >= top) ? 16'h0000 : cnt + 16'h0001;
        end
        return r;
    endfunction : tesc_step

    // Local names for the package's bit positions
    localparam int CTRL_CEN = tesc_pkg::CTRL_CEN;
    localparam int CTRL_URS = tesc_pkg::CTRL_URS;
    localparam int CTRL_OPM = tesc_pkg::CTRL_OPM;
    localparam int CTRL_DIR = tesc_pkg::CTRL_DIR;
    localparam int CTRL_XOR = tesc_pkg::CTRL_XOR;
    localparam int SLV_SMS_LSB = tesc_pkg::SLV_SMS_LSB;
    localparam int SLV_TS_LSB = tesc_pkg::SLV_TS_LSB;
    localparam int CH_OCM_LSB = tesc_pkg::CH_OCM_LSB;
    localparam int CH_FE = tesc_pkg::CH_FE;
    localparam int CH_P1 = tesc_pkg::CH_P1;
    localparam int CH_P2 = tesc_pkg::CH_P2;
    localparam int FLG_UIF = tesc_pkg::FLG_UIF;
    localparam int FLG_TIF = tesc_pkg::FLG_TIF;
    localparam int EVT_UG = tesc_pkg::EVT_UG;

    // Registers
    logic [7:0] ctrl;
    logic [7:0] slave;
    logic [9:0] chan;
    logic [15:0] arr_buf;
    logic [15:0] arr_act;
    logic [15:0] cmp_buf;
    logic [15:0] cmp_act;
    logic [15:0] psc;
    logic [15:0] psc_cnt;
    logic [15:0] cnt;
    logic [6:0] flags;
    logic tie_en;
    logic ref_q;
    logic out_q;
    logic hold_q;
    logic lt_q;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] prev;
    tesc_gate_e gate;
    tesc_gate_e next_gate;

    wire [2:0] sms = ctrl[CTRL_CEN] ? slave[SLV_SMS_LSB +: 3] : slave[SLV_SMS_LSB +: 3];
    wire [2:0] ts = slave[SLV_TS_LSB +: 3];
    wire [2:0] ocm = chan[CH_OCM_LSB +: 3];
    wire pwm_mode = (ocm == tesc_pkg::OCM_PWM1) || (ocm == tesc_pkg::OCM_PWM2);

    // APB decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire a_ctrl = paddr == tesc_pkg::OFF_CTRL;
    wire a_slave = paddr == tesc_pkg::OFF_SLAVE;
    wire a_chan = paddr == tesc_pkg::OFF_CHAN;
    wire a_arr = paddr == tesc_pkg::OFF_ARR;
    wire a_cmp = paddr == tesc_pkg::OFF_CMP;
    wire a_psc = paddr == tesc_pkg::OFF_PSC;
    wire a_cnt = paddr == tesc_pkg::OFF_CNT;
    wire a_flag = paddr == tesc_pkg::OFF_FLAG;
    wire a_ien = paddr == tesc_pkg::OFF_IEN;
    wire a_evt = paddr == tesc_pkg::OFF_EVT;
    wire mapped = a_ctrl | a_slave | a_chan | a_arr | a_cmp | a_psc | a_cnt | a_flag | a_ien
                  | a_evt;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // Input path: XOR, two-flop sync, polarity
    wire raw1 = ctrl[CTRL_XOR] ? (pins.second_encoder_input ^ pins.chan3 ^ pins.chan4)
                               : pins.first_encoder_input; // R12
    wire [1:0] raw = {pins.second_encoder_input, raw1};
    wire first_fp = s2[0] ^ chan[CH_P1]; // R22
    wire second_fp = s2[1] ^ chan[CH_P2]; // R22
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            prev <= 2'h0;
        end
        else
        begin
            s1 <= {1'b0, raw}; // R24 R21
            s2 <= s1;
            prev <= {second_fp, first_fp};
        end
    end
    wire e1 = first_fp != prev[0];
    wire e2 = second_fp != prev[1];
    wire rise1 = e1 && first_fp;
    wire rise2 = e2 && second_fp;

    // Trigger selection
    wire trig_lvl = (ts == tesc_pkg::TS_SECOND) ? second_fp : first_fp; // R15
    wire trig_edge = (ts == tesc_pkg::TS_SECOND) ? rise2 : rise1;

    // Encoder direction
    wire enc = (sms == tesc_pkg::SMS_ENC1) || (sms == tesc_pkg::SMS_ENC2)
               || (sms == tesc_pkg::SMS_ENC12); // R4
    wire dir1 = first_fp ? second_fp : !second_fp; // R9
    wire dir2 = second_fp ? first_fp : !first_fp; // R10
    wire enc_dn1 = dir1;
    wire enc_dn2 = !dir2 ? 1'b1 : 1'b0;
    wire cnt1 = e1 && (sms != tesc_pkg::SMS_ENC2); // R11
    wire cnt2 = e2 && (sms != tesc_pkg::SMS_ENC1); // R11
    wire enc_step = enc && ctrl[CTRL_CEN] && (cnt1 || cnt2); // R5
    wire enc_dir_upd = enc && (e1 || e2); // R6
    wire enc_down = e1 ? enc_dn1 : enc_dn2;

    // Slave modes
    wire rst_trig = (sms == tesc_pkg::SMS_RESET) && trig_edge; // R13
    wire gated = sms == tesc_pkg::SMS_GATED;
    wire gate_run = gated && ctrl[CTRL_CEN] && trig_lvl; // R18 R19
    always_comb
    begin
        next_gate = gate;
        case (gate)
            TESC_IDLE: next_gate = gate_run ? TESC_ON : TESC_OFF;
            TESC_OFF: next_gate = gate_run ? TESC_ON : TESC_OFF;
            TESC_ON: next_gate = gate_run ? TESC_ON : TESC_OFF;
            default: next_gate = TESC_IDLE;
        endcase
        if (!gated)
        begin
            next_gate = TESC_IDLE;
        end
    end
    wire gate_evt = gated && (gate != TESC_IDLE) && (next_gate != gate); // R20

    // Counting on the prescaled internal clock
    wire normal_run = !enc && ctrl[CTRL_CEN] && (!gated || gate_run); // R8
    wire psc_tick = normal_run && (psc_cnt >= psc);
    wire wrap = psc_tick && (ctrl[CTRL_DIR] ? cnt == 16'h0000 : cnt >= arr_act);
    wire ug = wr && a_evt && pwdata[EVT_UG];
    wire upd = ug || wrap || (rst_trig && !ctrl[CTRL_URS]); // R14
    wire opm_start = ctrl[CTRL_OPM] && trig_edge && (sms != tesc_pkg::SMS_RESET)
                     && !gated && !enc; // R1
    wire fast = chan[CH_FE] && pwm_mode && opm_start; // R2 R3
    wire match = cnt == cmp_act;
    wire match_lvl = (ocm == tesc_pkg::OCM_PWM2);
    wire cmp_lt = cnt < cmp_act;
    // Forced level survives until the comparison result next moves
    wire pwm_hold = hold_q && pwm_mode && (cmp_lt == lt_q); // R2
    wire trig_set = rst_trig || gate_evt || opm_start; // R16 R20

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= 8'h00;
            slave <= 8'h00;
            chan <= 10'h000;
            arr_buf <= tesc_pkg::ARR_RESET;
            arr_act <= tesc_pkg::ARR_RESET;
            cmp_buf <= 16'h0000;
            cmp_act <= 16'h0000;
            psc <= 16'h0000;
            psc_cnt <= 16'h0000;
            cnt <= 16'h0000;
            flags <= 7'h00;
            tie_en <= 1'b0;
            ref_q <= 1'b0;
            out_q <= 1'b0;
            hold_q <= 1'b0;
            lt_q <= 1'b0;
            gate <= TESC_IDLE;
        end
        else
        begin
            gate <= next_gate;
            if (wr && a_ctrl)
            begin
                ctrl <= pwdata[7:0];
            end
            if (opm_start)
            begin
                ctrl[CTRL_CEN] <= 1'b1; // R1
            end
            else if (upd && ctrl[CTRL_OPM] && !ug)
            begin
                ctrl[CTRL_CEN] <= 1'b0; // R23
            end
            if (enc_dir_upd)
            begin
                ctrl[CTRL_DIR] <= enc_down; // R6
            end
            if (wr && a_slave)
            begin
                slave <= pwdata[7:0];
            end
            if (wr && a_chan)
            begin
                chan <= pwdata[9:0];
            end
            if (wr && a_arr)
            begin
                arr_buf <= pwdata[15:0];
            end
            if (wr && a_cmp)
            begin
                cmp_buf <= pwdata[15:0];
            end
            if (wr && a_psc)
            begin
                psc <= pwdata[15:0];
            end
            if (wr && a_ien)
            begin
                tie_en <= pwdata[FLG_TIF];
            end
            if (upd)
            begin
                arr_act <= arr_buf; // R14
                cmp_act <= cmp_buf;
            end
            // Counter and prescaler
            if (rst_trig || ug)
            begin
                cnt <= 16'h0000; // R13 R16
                psc_cnt <= 16'h0000;
            end
            else if (wr && a_cnt)
            begin
                cnt <= pwdata[15:0];
            end
            else if (enc_step)
            begin
                cnt <= tesc_step(cnt, arr_act, enc_down); // R5 R7
            end
            else if (psc_tick)
            begin
                psc_cnt <= 16'h0000;
                cnt <= tesc_step(cnt, arr_act, ctrl[CTRL_DIR]);
            end
            else if (normal_run)
            begin
                psc_cnt <= psc_cnt + 16'h0001;
            end
            // Flags: write one to clear, hardware set wins
            if (wr && a_flag)
            begin
                flags <= flags & ~pwdata[6:0];
            end
            if (trig_set)
            begin
                flags[FLG_TIF] <= 1'b1; // R25
            end
            if (upd && !(rst_trig && ctrl[CTRL_URS]))
            begin
                flags[FLG_UIF] <= 1'b1;
            end
            // Reference output
            lt_q <= cmp_lt;
            hold_q <= fast || pwm_hold;
            if (fast)
            begin
                ref_q <= match_lvl; // R2
            end
            else if (pwm_hold)
            begin
                ref_q <= ref_q;
            end
            else if (ocm == tesc_pkg::OCM_PWM1)
            begin
                ref_q <= cmp_lt;
            end
            else if (ocm == tesc_pkg::OCM_PWM2)
            begin
                ref_q <= !cmp_lt;
            end
            else if (match && ocm == 3'h1)
            begin
                ref_q <= 1'b1;
            end
            else if (match && ocm == 3'h2)
            begin
                ref_q <= 1'b0;
            end
            out_q <= fast ? (match_lvl ^ chan[CH_P1]) : (ref_q ^ chan[CH_P1]); // R2
        end
    end

    assign trigger_irq = flags[FLG_TIF] && tie_en; // R17 R25

    always_comb
    begin
        prdata = tesc_pkg::READ_ZERO;
        if (a_ctrl)
        begin
            prdata = {24'h0, ctrl};
        end
        else if (a_slave)
        begin
            prdata = {24'h0, slave};
        end
        else if (a_chan)
        begin
            prdata = {22'h0, chan};
        end
        else if (a_arr)
        begin
            prdata = {16'h0, arr_buf};
        end
        else if (a_cmp)
        begin
            prdata = {16'h0, cmp_buf};
        end
        else if (a_psc)
        begin
            prdata = {16'h0, psc};
        end
        else if (a_cnt)
        begin
            prdata = {16'h0, cnt};
        end
        else if (a_flag)
        begin
            prdata = {25'h0, flags};
        end
        else if (a_ien)
        begin
            prdata = {25'h0, tie_en, 6'h00};
        end
    end

    assign state.count = cnt;
    assign state.count_direction_bit = ctrl[CTRL_DIR];
    assign state.update_event = flags[FLG_UIF];
    assign state.channel_reference_signal = ref_q;
    assign state.channel_output = out_q;

endmodule : tesc_core

/* sim/tesc_core_chk.sv */
`timescale 1ns/10ps
module tesc_core_chk
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tesc_pkg::tesc_pins_s pins,
    input wire tesc_pkg::tesc_state_s state,
    input wire logic trigger_irq
);
    logic wr;
    logic [3:0] pins_q;
    logic [7:0] act;
    assign wr = psel && penable && pwrite;
    // Eight cycles of history span the input synchroniser
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pins_q <= 4'h0;
            act <= 8'h0;
        end
        else
        begin
            pins_q <= pins;
            act <= {act[6:0], wr || (pins != pins_q)};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_count_step: assert property (!$stable(state.count) && !$past(wr) |->
        state.count == $past(state.count) + 16'h1 ||
        state.count == $past(state.count) - 16'h1 ||
        state.count == 16'h0 || $past(state.count) == 16'h0)
        else $error("count jumped");
    a_dir_cause: assert property ($changed(state.count_direction_bit) |-> |act)
        else $error("direction moved without cause");
    a_irq_fall: assert property ($fell(trigger_irq) |-> $past(wr))
        else $error("request dropped without write");
    a_irq_rise: assert property ($rose(trigger_irq) |-> |act)
        else $error("request rose without cause");
    a_upd_fall: assert property ($fell(state.update_event) |-> $past(wr))
        else $error("update flag dropped without write");
    c_trigger: cover property ($rose(trigger_irq));
    c_dir: cover property ($changed(state.count_direction_bit));
    c_refused: cover property (pslverr);
endmodule : tesc_core_chk

bind tesc_core tesc_core_chk u_chk (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .state(state), .trigger_irq(trigger_irq));

/* sim/tesc_enc_model.sv */
`timescale 1ns/10ps
module tesc_enc_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic step,
    input wire logic fwd,
    input wire logic [1:0] hall,
    output tesc_pkg::tesc_pins_s pins
);
    logic [1:0] phase;
    // Gray walk: only one phase line moves per step
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            phase <= 2'h0;
        else if (step)
            phase <= fwd ? phase + 2'h1 : phase - 2'h1;
    end
    assign pins.first_encoder_input = phase[1] ^ phase[0];
    assign pins.second_encoder_input = phase[1];
    assign pins.chan3 = hall[0];
    assign pins.chan4 = hall[1];
endmodule : tesc_enc_model

/* sim/timer_encoder_slave_ctrl_tb.sv */
`timescale 1ns/10ps
module timer_encoder_slave_ctrl_tb;
    typedef struct {
        logic [2:0] sms;
        logic pol;
        logic f;
        logic [15:0] cnt;
        logic dir;
    } tesc_row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic step = 1'b0;
    logic fwd = 1'b0;
    logic [1:0] hall = 2'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trigger_irq;
    logic err;
    logic [31:0] rd;
    logic [15:0] c1;
    tesc_pkg::tesc_pins_s pins;
    tesc_pkg::tesc_state_s state;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    // Four steps put two edges on each line from any start phase
    tesc_row_s rows [5] = '{
        '{tesc_pkg::SMS_ENC12, 1'b0, 1'b1, 16'h14, 1'b0},
        '{tesc_pkg::SMS_ENC12, 1'b0, 1'b0, 16'hC, 1'b1},
        '{tesc_pkg::SMS_ENC1, 1'b0, 1'b1, 16'h12, 1'b0},
        '{tesc_pkg::SMS_ENC2, 1'b0, 1'b0, 16'hE, 1'b1},
        '{tesc_pkg::SMS_ENC12, 1'b1, 1'b1, 16'hC, 1'b1}
    };

    tesc_core uut
    (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .state(state), .trigger_irq(trigger_irq)
    );
    tesc_enc_model u_enc
    (
        .clk(clk), .resetn(resetn), .step(step), .fwd(fwd), .hall(hall), .pins(pins)
    );

    always #2.5 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wreg

    task automatic stp(input logic f, input int n);
        repeat (n)
        begin
            fwd <= f;
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask : stp

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (rows[i])
        begin
            wreg(tesc_pkg::OFF_CTRL, 32'h0);
            wreg(tesc_pkg::OFF_SLAVE, 32'h0);
            wreg(tesc_pkg::OFF_CHAN, {23'h0, rows[i].pol, 8'h0});
            wreg(tesc_pkg::OFF_SLAVE, {29'h0, rows[i].sms});
            wreg(tesc_pkg::OFF_CNT, 32'h10);
            wreg(tesc_pkg::OFF_CTRL, 32'h1);
            stp(rows[i].f, 4);
            chk(state.count, rows[i].cnt);
            apb(1'b0, tesc_pkg::OFF_CTRL, 32'h0);
            chk(rd, {27'h0, rows[i].dir, 4'h1});
            $display("encoder row %0d done", i);
        end
        wreg(tesc_pkg::OFF_CTRL, 32'h0);
        wreg(tesc_pkg::OFF_CHAN, 32'h0);
        wreg(tesc_pkg::OFF_ARR, 32'h5);
        wreg(tesc_pkg::OFF_EVT, 32'h1);
        wreg(tesc_pkg::OFF_CNT, 32'h0);
        wreg(tesc_pkg::OFF_CTRL, 32'h1);
        stp(1'b0, 1);
        chk(state.count, 16'h5);
        stp(1'b1, 2);
        chk(state.count, 16'h1);
        $display("wrap test done");
        wreg(tesc_pkg::OFF_CTRL, 32'h0);
        wreg(tesc_pkg::OFF_SLAVE, 32'h0);
        wreg(tesc_pkg::OFF_ARR, 32'hFFFF);
        wreg(tesc_pkg::OFF_EVT, 32'h1);
        while (pins.first_encoder_input || pins.second_encoder_input) stp(1'b1, 1);
        wreg(tesc_pkg::OFF_SLAVE, 32'h54);
        wreg(tesc_pkg::OFF_IEN, 32'h40);
        wreg(tesc_pkg::OFF_FLAG, 32'h41);
        wreg(tesc_pkg::OFF_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        stp(1'b1, 1);
        chk(state.count < 16'h10, 1'b1);
        chk(trigger_irq, 1'b1);
        chk(state.update_event, 1'b1);
        wreg(tesc_pkg::OFF_FLAG, 32'h41);
        chk(trigger_irq, 1'b0);
        wreg(tesc_pkg::OFF_IEN, 32'h0);
        wreg(tesc_pkg::OFF_CTRL, 32'h5);
        stp(1'b1, 4);
        chk(trigger_irq, 1'b0);
        apb(1'b0, tesc_pkg::OFF_FLAG, 32'h0);
        chk(rd, 32'h40);
        $display("reset mode test done");
        wreg(tesc_pkg::OFF_CTRL, 32'h0);
        wreg(tesc_pkg::OFF_SLAVE, 32'h55);
        wreg(tesc_pkg::OFF_FLAG, 32'h41);
        c1 = state.count;
        repeat (10) @(posedge clk);
        chk(state.count, c1);
        wreg(tesc_pkg::OFF_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        chk(state.count > c1, 1'b1);
        apb(1'b0, tesc_pkg::OFF_FLAG, 32'h0);
        chk(rd[6], 1'b1);
        wreg(tesc_pkg::OFF_FLAG, 32'h41);
        stp(1'b1, 2);
        c1 = state.count;
        repeat (10) @(posedge clk);
        chk(state.count, c1);
        apb(1'b0, tesc_pkg::OFF_FLAG, 32'h0);
        chk(rd[6], 1'b1);
        $display("gated mode test done");
        hall <= 2'h1;
        wreg(tesc_pkg::OFF_CTRL, 32'h0);
        wreg(tesc_pkg::OFF_SLAVE, 32'h54);
        wreg(tesc_pkg::OFF_CTRL, 32'h81);
        wreg(tesc_pkg::OFF_FLAG, 32'h41);
        hall <= 2'h3;
        repeat (5) @(posedge clk);
        apb(1'b0, tesc_pkg::OFF_FLAG, 32'h0);
        chk(rd[6], 1'b1);
        $display("xor test done");
        for (int k = 0; k < 2; k++)
        begin
            wreg(tesc_pkg::OFF_CTRL, 32'h0);
            wreg(tesc_pkg::OFF_SLAVE, 32'h0);
            while (pins.first_encoder_input || pins.second_encoder_input) stp(1'b1, 1);
            wreg(tesc_pkg::OFF_SLAVE, 32'h50);
            wreg(tesc_pkg::OFF_CHAN, {25'h0, k ? tesc_pkg::OCM_PWM2 : tesc_pkg::OCM_PWM1, 4'h4});
            wreg(tesc_pkg::OFF_ARR, 32'h40);
            wreg(tesc_pkg::OFF_CMP, 32'h30);
            wreg(tesc_pkg::OFF_EVT, 32'h1);
            wreg(tesc_pkg::OFF_CNT, 32'h0);
            wreg(tesc_pkg::OFF_CTRL, 32'h8);
            stp(1'b1, 1);
            chk(state.channel_reference_signal, k[0]);
            chk(state.channel_output, k[0]);
            apb(1'b0, tesc_pkg::OFF_CTRL, 32'h0);
            chk(rd[0], 1'b1);
            repeat (100) @(posedge clk);
            apb(1'b0, tesc_pkg::OFF_CTRL, 32'h0);
            chk(rd[0], 1'b0);
            chk(state.count, 16'h0);
            $display("one-pulse test %0d done", k);
        end
        apb(1'b0, 32'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("refused access test done");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk(trigger_irq, 1'b0);
        apb(1'b0, tesc_pkg::OFF_ARR, 32'h0);
        chk(rd, {16'h0, tesc_pkg::ARR_RESET});
        $display("reset test done");
        tally_and_finish();
    end
endmodule : timer_encoder_slave_ctrl_tb
